/* logic/fe_rx_pkg.sv */
// Constants and carrier types for the 100 Mbit/s receive front end.
// Assumes one 200 MHz core clock; the hold cycle count below is derived from it.
package fe_rx_pkg;

   // Core clock and line rate
   localparam int CLOCK_MHZ = 200;
   localparam int LINE_RATE_MBPS = 125;

   // Descrambler hold timer, 722 us expressed in core cycles
   localparam int HOLD_TIME_US = 722;
   localparam int HOLD_CYCLES = HOLD_TIME_US * CLOCK_MHZ;

   // Idle burst needed to lock the descrambler
   localparam int IDLE_RUN_BITS = 40;
   localparam int RUN_COUNT_BITS = 6;

   // Idle symbols within one hold interval that keep the lock
   localparam int IDLE_SYMBOL_THRESHOLD = 8;
   localparam int IDLE_COUNT_BITS = 8;

   // Deciphering LFSR, x^11 + x^9 + 1
   localparam int LFSR_WIDTH = 11;
   localparam int LFSR_TAP_HIGH = 10;
   localparam int LFSR_TAP_LOW = 8;
   localparam logic [10:0] LFSR_RESET = 11'h000;

   // Code groups and delimiters
   localparam int CODE_GROUP_BITS = 5;
   localparam int PAIR_BITS = 10;
   localparam logic [3:0] PAIR_LAST_BIT = 4'h9;
   localparam logic [2:0] IDLE_ONES_LAST = 3'h4;
   localparam logic [9:0] SSD_PATTERN = 10'h311;
   localparam logic [9:0] IDLE_PAIR = 10'h3ff;

   // Output buffer
   localparam int FIFO_DEPTH = 4;

   // One aligned pair of code groups, first received bit in groups[9]
   typedef struct packed {
      logic startPair;
      logic [9:0] groups;
   } code_pair_s;

   localparam int PAIR_WORD_BITS = $bits(code_pair_s);

endpackage : fe_rx_pkg

/* logic/pair_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low asynchronous reset already synchronised.
`timescale 1ns/1ps
module pair_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rstCore_n,
   // Filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] LAST_SLOT = PW'(DEPTH - 1);
   localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wrPtr;
      logic [PW-1:0] rdPtr;
      logic [CW-1:0] count;
   } fifo_state_s;

   fifo_state_s s;
   fifo_state_s next_s;
   logic doPush;
   logic doPop;

   assign inReady = (s.count != FULL_COUNT);
   assign outValid = (s.count != '0);
   assign outData = s.mem[s.rdPtr];
   assign doPush = inValid && inReady;
   assign doPop = outValid && outReady;

   always_comb begin
      next_s = s;
      if (doPush) begin
         next_s.mem[s.wrPtr] = inData;
         next_s.wrPtr = (s.wrPtr == LAST_SLOT) ? '0 : s.wrPtr + 1'b1;
      end
      if (doPop) begin
         next_s.rdPtr = (s.rdPtr == LAST_SLOT) ? '0 : s.rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
         next_s.count = s.count + 1'b1;
      end else if (doPop && !doPush) begin
         next_s.count = s.count - 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstCore_n) begin
      if (!rstCore_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

endmodule : pair_fifo

/* logic/fe_rx_descramble_align.sv */
// Receive front end of a 100 Mbit/s PHY: NRZI decode, descramble, align.
// Assumes a recovered serial bit with a toggle strobe from the timing
// recovery domain, and a 200 MHz core clock well above the bit rate.
//
// What this block does
// - Accepts 125 Mbit/s stream, copper or fiber
// - Converts NRZI to NRZ, unaligned
// - Locks LFSR after idle run of 40
// - Locked: XOR each bit with LFSR
// - On lock, start 722 us hold timer
// - Enough idles reload the hold timer
// - Too few idles: drop lock, restart
// - Align code groups on 11000 10001 pair
// - Bypass for each major stage
// - Loopback path for diagnostics
// - Internal reset from sampled RC input
`timescale 1ns/1ps
module fe_rx_descramble_align
   import fe_rx_pkg::*;
#(
   parameter int HOLD_COUNT = HOLD_CYCLES,
   parameter int IDLE_THRESHOLD = IDLE_SYMBOL_THRESHOLD,
   parameter int DEPTH = FIFO_DEPTH
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic powerOnRcInput,
   output logic internalReset_n,
   // Recovered serial line
   input wire logic lineBit,
   input wire logic lineStrobe,
   output logic rxReady,
   // Loopback from the transmit path
   input wire logic loopbackEnable,
   input wire logic loopbackBit,
   input wire logic loopbackStrobe,
   // Stage bypasses
   input wire logic bypassNrzi,
   input wire logic bypassDescrambler,
   input wire logic bypassAlign,
   // Aligned code pairs
   output logic pairValid,
   input wire logic pairReady,
   output code_pair_s pairData,
   // Status
   output logic descramblerLocked,
   output logic codeAligned,
   output logic overflow
);
   localparam int HW = $clog2(HOLD_COUNT + 1);
   localparam logic [HW-1:0] HOLD_LOAD = HW'(HOLD_COUNT);
   localparam logic [IDLE_COUNT_BITS-1:0] IDLE_LIMIT = IDLE_COUNT_BITS'(IDLE_THRESHOLD);
   localparam logic [RUN_COUNT_BITS-1:0] RUN_LIMIT = RUN_COUNT_BITS'(IDLE_RUN_BITS);

   typedef struct packed {
      logic [1:0] lineSync;
      logic [1:0] strobeSync;
      logic strobeSeen;
      logic [1:0] rcSync;
      logic internalReset_n;
      logic prevLevel;
      logic [LFSR_WIDTH-1:0] lfsr;
      logic [RUN_COUNT_BITS-1:0] matchRun;
      logic locked;
      logic [HW-1:0] holdTimer;
      logic [IDLE_COUNT_BITS-1:0] idleCount;
      logic [2:0] onesRun;
      logic [PAIR_BITS-1:0] window;
      logic aligned;
      logic [3:0] bitPos;
      logic overflow;
   } rx_state_s;

   rx_state_s s;
   rx_state_s next_s;
   logic [1:0] rstSync;
   logic coreRst_n;
   logic pushValid;
   logic pushReady;
   code_pair_s pushData;

   // Variables of the combinational pass
   logic bitEvent;
   logic srcBit;
   logic nrzBit;
   logic keyBit;
   logic candidate;
   logic dataBit;
   logic streamOk;
   logic [PAIR_BITS-1:0] shifted;

   // Core reset released through two flops
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end

   assign coreRst_n = rstSync[1];

   // Status outputs straight from flops; rxReady decoded from the buffer count
   assign internalReset_n = s.internalReset_n;
   assign descramblerLocked = s.locked;
   assign codeAligned = s.aligned;
   assign overflow = s.overflow;
   assign rxReady = pushReady;

   always_comb begin
      next_s = s;
      pushValid = 1'b0;
      pushData = '0;
      bitEvent = 1'b0;
      srcBit = 1'b0;
      nrzBit = 1'b0;
      keyBit = 1'b0;
      candidate = 1'b0;
      dataBit = 1'b0;
      streamOk = 1'b0;
      shifted = '0;

      // Pin synchronisers, first stage only feeds the second
      next_s.lineSync = {s.lineSync[0], lineBit};
      next_s.strobeSync = {s.strobeSync[0], lineStrobe};
      next_s.strobeSeen = s.strobeSync[1];

      next_s.rcSync = {s.rcSync[0], powerOnRcInput};
      next_s.internalReset_n = s.rcSync[1];

      // line bit or loopback selects source
      if (loopbackEnable) begin
         srcBit = loopbackBit;
         bitEvent = loopbackStrobe;
      end else begin
         srcBit = s.lineSync[1];
         bitEvent = s.strobeSync[1] ^ s.strobeSeen;
      end

      nrzBit = bypassNrzi ? srcBit : (srcBit ^ s.prevLevel);

      keyBit = s.lfsr[LFSR_TAP_HIGH] ^ s.lfsr[LFSR_TAP_LOW];
      candidate = ~nrzBit;

      if (bypassDescrambler) begin
         dataBit = nrzBit;
      end else begin
         dataBit = nrzBit ^ keyBit;
      end
      streamOk = s.locked || bypassDescrambler;

      if (s.locked && !bypassDescrambler && s.holdTimer != '0) begin
         next_s.holdTimer = s.holdTimer - 1'b1;
      end

      if (bitEvent) begin
         next_s.prevLevel = srcBit;

         if (!bypassDescrambler && !s.locked) begin
            // idle run of 40 consistent bits
            next_s.lfsr = {s.lfsr[LFSR_WIDTH-2:0], candidate};
            if (candidate == keyBit) begin
               if (s.matchRun == RUN_LIMIT - 1'b1) begin
                  next_s.locked = 1'b1;
                  next_s.matchRun = '0;
                  next_s.holdTimer = HOLD_LOAD;
                  next_s.idleCount = '0;
                  next_s.onesRun = '0;
               end else begin
                  next_s.matchRun = s.matchRun + 1'b1;
               end
            end else begin
               next_s.matchRun = '0;
            end
         end else if (!bypassDescrambler) begin
            next_s.lfsr = {s.lfsr[LFSR_WIDTH-2:0], keyBit};
         end

         // Unaligned idle symbol count, five ones each
         if (streamOk) begin
            if (!dataBit) begin
               next_s.onesRun = '0;
            end else if (s.onesRun == IDLE_ONES_LAST) begin
               next_s.onesRun = '0;
               if (s.idleCount + 1'b1 >= IDLE_LIMIT) begin
                  next_s.idleCount = '0;
                  next_s.holdTimer = HOLD_LOAD;
               end else begin
                  next_s.idleCount = s.idleCount + 1'b1;
               end
            end else begin
               next_s.onesRun = s.onesRun + 1'b1;
            end
         end

         shifted = {s.window[PAIR_BITS-2:0], dataBit};
         next_s.window = shifted;
         if (streamOk) begin
            if (!s.aligned) begin
               if (bypassAlign) begin
                  next_s.aligned = 1'b1;
                  // First bit already opens the pair
                  next_s.bitPos = 4'h1;
               end else if (shifted == SSD_PATTERN) begin
                  next_s.aligned = 1'b1;
                  next_s.bitPos = '0;
                  pushValid = 1'b1;
                  pushData.startPair = 1'b1;
                  pushData.groups = shifted;
               end
            end else if (s.bitPos == PAIR_LAST_BIT) begin
               // fixed boundary after the start pair
               next_s.bitPos = '0;
               pushValid = 1'b1;
               pushData.startPair = 1'b0;
               pushData.groups = shifted;
               if (shifted == IDLE_PAIR && !bypassAlign) begin
                  next_s.aligned = 1'b0;
               end
            end else begin
               next_s.bitPos = s.bitPos + 1'b1;
            end
         end
      end

      // Lost pairs are flagged until reset
      if (pushValid && !pushReady) begin
         next_s.overflow = 1'b1;
      end

      // expiry drops lock and restarts search
      if (s.locked && !bypassDescrambler && s.holdTimer == '0
          && next_s.holdTimer == '0) begin
         next_s.locked = 1'b0;
         next_s.lfsr = LFSR_RESET;
         next_s.matchRun = '0;
         next_s.idleCount = '0;
         next_s.onesRun = '0;
         next_s.aligned = 1'b0;
         next_s.bitPos = '0;
      end

      // Without a stream, alignment cannot stand
      if (!streamOk && !next_s.locked) begin
         next_s.aligned = 1'b0;
      end

      if (!s.internalReset_n) begin
         next_s.prevLevel = 1'b0;
         next_s.lfsr = LFSR_RESET;
         next_s.matchRun = '0;
         next_s.locked = 1'b0;
         next_s.holdTimer = '0;
         next_s.idleCount = '0;
         next_s.onesRun = '0;
         next_s.window = '0;
         next_s.aligned = 1'b0;
         next_s.bitPos = '0;
         next_s.overflow = 1'b0;
         pushValid = 1'b0;
      end
   end

   always_ff @(posedge clock or negedge coreRst_n) begin
      if (!coreRst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   // Output buffer, back-pressure shown on rxReady
   pair_fifo #(
      .WIDTH(PAIR_WORD_BITS),
      .DEPTH(DEPTH)
   ) u_pair_fifo (
      .clock(clock),
      .rstCore_n(coreRst_n),
      .inValid(pushValid),
      .inReady(pushReady),
      .inData(pushData),
      .outValid(pairValid),
      .outReady(pairReady),
      .outData(pairData)
   );

endmodule : fe_rx_descramble_align

/* verification/fe_rx_descramble_align_sva.sv */
// Checker for the receive front end, bound to its top module.
// Assumes HOLD_COUNT is handed on from the instance.
`timescale 1ns/1ps
module fe_rx_checker
   import fe_rx_pkg::*;
#(
   parameter int HOLD_COUNT = 400
) (
   // Clock, reset and descrambler bypass
   input wire logic clock,
   input wire logic rst_n,
   input wire logic powerOnRcInput,
   input wire logic internalReset_n,
   input wire logic bypassDescrambler,
   // Pair side
   input wire logic rxReady,
   input wire logic pairValid,
   input wire logic pairReady,
   input wire code_pair_s pairData,
   // Status
   input wire logic descramblerLocked,
   input wire logic codeAligned,
   input wire logic overflow
);
   int lockAge;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         lockAge <= 0;
      end else begin
         lockAge <= descramblerLocked ? lockAge + 1 : 0;
      end
   end
   a_rc_holds_reset: assert property ((!powerOnRcInput) [*4] |-> !internalReset_n)
      else $error("internal reset high while RC low");
   a_reset_clears_state: assert property (!internalReset_n |=> !descramblerLocked)
      else $error("lock held through internal reset");
   a_lock_needs_run: assert property ($rose(descramblerLocked) |-> $past(internalReset_n, 40))
      else $error("lock sooner than a 40 bit run");
   a_hold_lock_span: assert property ($fell(descramblerLocked) && internalReset_n
      && $past(internalReset_n) && !bypassDescrambler |-> lockAge >= HOLD_COUNT - 1)
      else $error("lock dropped before hold time");
   a_drop_clears_align: assert property ($fell(descramblerLocked) && !bypassDescrambler
      |-> !codeAligned)
      else $error("alignment kept after lock loss");
   a_start_is_ssd: assert property (pairValid && pairData.startPair
      |-> pairData.groups == SSD_PATTERN)
      else $error("start flag on a non delimiter pair");
   a_pair_held: assert property (pairValid && !pairReady |=> pairValid && $stable(pairData))
      else $error("pair changed while stalled");
   a_full_not_empty: assert property (!rxReady |-> pairValid && !$fell(overflow))
      else $error("full buffer with nothing valid");
   c_lock: cover property ($rose(descramblerLocked));
   c_start: cover property (pairValid && pairData.startPair);
   c_overflow: cover property ($rose(overflow));
endmodule : fe_rx_checker

bind fe_rx_descramble_align fe_rx_checker #(.HOLD_COUNT(HOLD_COUNT)) checker_i (.clock, .rst_n,
   .powerOnRcInput, .internalReset_n, .bypassDescrambler, .rxReady, .pairValid, .pairReady,
   .pairData, .descramblerLocked, .codeAligned, .overflow);

/* verification/fe_link_partner.sv */
// Remote link partner: scrambles, NRZI codes, sends with a toggle strobe.
// Assumes the 200 MHz core clock; one bit every four clocks.
`timescale 1ns/1ps
module fe_link_partner (
   // Clock
   input wire logic clock,
   // Line
   output logic lineBit,
   output logic lineStrobe
);
   logic [10:0] scr = 11'h5a3;
   initial begin
      lineBit = 1'b0;
      lineStrobe = 1'b0;
   end
   task automatic send(input logic [9:0] d);
      logic key;
      for (int i = 9; i >= 0; i--) begin
         @(posedge clock);
         key = scr[10] ^ scr[8];
         scr = {scr[9:0], key};
         if (d[i] ^ key) lineBit <= ~lineBit;
         lineStrobe <= ~lineStrobe;
         repeat (3) @(posedge clock);
      end
   endtask : send
endmodule : fe_link_partner

/* verification/fe_rx_descramble_align_tb_top.sv */
// Testbench for the receive front end, fed by the link partner.
// Assumes a short hold count so lock expiry fits a short run.
`timescale 1ns/1ps
module fe_rx_descramble_align_tb_top
   import fe_rx_pkg::*;
;
   localparam int HOLD = 400;
   logic clock = 1'b0;
   logic rst_n, powerOnRcInput, internalReset_n, lineBit, lineStrobe, rxReady;
   logic loopbackEnable, loopbackBit, loopbackStrobe, bypassNrzi, bypassDescrambler;
   logic bypassAlign, pairValid, pairReady, descramblerLocked, codeAligned, overflow;
   code_pair_s pairData;
   code_pair_s got[$];
   int nErrors = 0;
   int numChecks = 0;
   int cycles = 0;

   always #2.5 clock = ~clock;

   fe_link_partner partner (.clock, .lineBit, .lineStrobe);
   fe_rx_descramble_align #(.HOLD_COUNT(HOLD)) DUT (.clock, .rst_n, .powerOnRcInput,
      .internalReset_n, .lineBit, .lineStrobe, .rxReady, .loopbackEnable, .loopbackBit,
      .loopbackStrobe, .bypassNrzi, .bypassDescrambler, .bypassAlign, .pairValid,
      .pairReady, .pairData, .descramblerLocked, .codeAligned, .overflow);

   task automatic chk(input string what, input logic [10:0] seen, input logic [10:0] exp);
      numChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic endSim();
      $display("checks %0d mismatches %0d", numChecks, nErrors);
      if (nErrors == 0 && numChecks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : endSim

   always @(posedge clock) begin
      cycles++;
      if (pairValid === 1'b1 && pairReady === 1'b1) got.push_back(pairData);
      if (cycles == 20000) begin
         nErrors++;
         endSim();
      end
   end

   task automatic loopWord(input logic [9:0] d);
      for (int i = 9; i >= 0; i--) begin
         @(posedge clock);
         loopbackBit <= d[i];
         loopbackStrobe <= 1'b1;
         @(posedge clock);
         loopbackStrobe <= 1'b0;
      end
   endtask : loopWord

   task automatic testReset();
      repeat (10) @(posedge clock);
      chk("status", {internalReset_n, descramblerLocked, codeAligned, overflow, pairValid,
         rxReady}, 6'h01);
      powerOnRcInput <= 1'b1;
      repeat (6) @(posedge clock);
      chk("intReset", internalReset_n, 1'h1);
      $display("reset test done");
   endtask : testReset

   task automatic testLockAlign();
      repeat (6) partner.send(IDLE_PAIR);
      chk("locked", descramblerLocked, 1'h1);
      got.delete();
      partner.send(SSD_PATTERN);
      partner.send(10'h2a5);
      chk("aligned", codeAligned, 1'h1);
      partner.send(IDLE_PAIR);
      repeat (4) @(posedge clock);
      chk("pairs", 11'(got.size()), 11'h003);
      chk("ssd", got[0], 11'h711);
      chk("data", got[1], 11'h2a5);
      chk("idle", got[2], 11'h3ff);
      $display("lock and align test done");
   endtask : testLockAlign

   task automatic testHoldExpire();
      repeat (20) partner.send(IDLE_PAIR);
      chk("kept", descramblerLocked, 1'h1);
      repeat (14) partner.send(10'h000);
      chk("dropped", {descramblerLocked, codeAligned}, 2'h0);
      repeat (6) partner.send(IDLE_PAIR);
      chk("relock", descramblerLocked, 1'h1);
      $display("hold test done");
   endtask : testHoldExpire

   task automatic testBypass();
      rst_n <= 1'b0;
      {loopbackEnable, bypassNrzi, bypassDescrambler, bypassAlign} <= 4'hf;
      pairReady <= 1'b0;
      repeat (3) @(posedge clock);
      rst_n <= 1'b1;
      repeat (8) @(posedge clock);
      for (int w = 1; w <= 5; w++) loopWord(10'(w));
      repeat (4) @(posedge clock);
      chk("full", {rxReady, overflow, pairValid}, 3'h3);
      got.delete();
      pairReady <= 1'b1;
      repeat (8) @(posedge clock);
      chk("drained", {10'(got.size()), pairValid}, 11'h008);
      for (int k = 0; k < 4; k++) chk("word", got[k], 11'(k + 1));
      $display("bypass test done");
   endtask : testBypass

   initial begin
      {rst_n, powerOnRcInput, loopbackEnable, loopbackBit, loopbackStrobe} = 5'h00;
      {bypassNrzi, bypassDescrambler, bypassAlign, pairReady} = 4'h1;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      testReset();
      testLockAlign();
      testHoldExpire();
      testBypass();
      endSim();
   end
endmodule : fe_rx_descramble_align_tb_top
